// File: common/cspd_pkg.sv
/*
 * Constants and carriers for the configuration-status and power-down controller.
 * Assumes one 100 MHz clock, synchronous active-high reset, pins sampled synchronously.
 */
// What this block does
// - Low power_down_n holds device in power-down
// - Power-down disables user I/O, initialises flip-flops
// - Inputs read as low during power-down
// - Configuration contents survive power-down
// - Power-down halts configuration, restarts on release
// - Release enables inputs and flip-flops before outputs
// - Unscanned test output becomes plain three-state output
// - Test inputs bypass io_cell, usable by logic
// - config_busy_high high until I/O active
// - config_busy_low_n low until I/O active
// - Init pin low during stabilisation and clearing
// - External low init pin holds wait state
// - Master mode waits extra 30 to 300 us
// - Data error drives init pin low
// - Init pin becomes user I/O once active
// - Primary global inputs drive global nets or I/O
// - Mode inputs sampled after init pin rises
// - Clear release: finish cycle, one more, then wait
// - Open-drain completion pin signals configuration done
package cspd_pkg;

    localparam int CLK_PERIOD_NS   = 10;
    localparam int MASTER_WAIT_MIN_US = 30;
    localparam int MASTER_WAIT_MAX_US = 300;
    localparam int MASTER_WAIT_CYC =
        (MASTER_WAIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STABLE_CYC_DEF  = 16;
    localparam int CLEAR_CYC_DEF   = 8;
    localparam int CNT_W           = 16;
    localparam int NUM_GLOBAL      = 4;
    localparam int NUM_USER_IO     = 8;
    localparam int MEM_DEPTH       = 16;
    localparam int MEM_AW          = 4;
    localparam int MEM_DW          = 8;
    localparam logic [1:0] MODE_MASTER_SERIAL = 2'h0;
    localparam logic [1:0] MODE_RESET_VAL     = 2'h3;

    typedef enum {
        ST_STABILISE, ST_CLEAR, ST_CLEAR_LAST, ST_WAIT, ST_MASTER_WAIT,
        ST_CONFIG, ST_ERROR, ST_INPUTS_ON, ST_USER
    } cspd_state_t;

    typedef struct packed {
        logic                   configStart;
        logic                   configData;
        logic                   configError;
        logic                   configEnd;
    } cspd_cfg_t;

    typedef struct packed {
        logic [NUM_USER_IO-1:0] out;
        logic [NUM_USER_IO-1:0] oe;
    } cspd_io_t;

endpackage

// File: core/cspd_cfg_mem.sv
/*
 * Small configuration memory with registered read data.
 * Assumes writes only while configuring; contents never cleared by power-down.
 */
`timescale 1ns/1ps
module cspd_cfg_mem
    import cspd_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Write port
    input  wire logic              wrEn,
    input  wire logic [MEM_AW-1:0] wrAddr,
    input  wire logic [MEM_DW-1:0] wrData,
    // Read port
    input  wire logic [MEM_AW-1:0] rdAddr,
    output logic      [MEM_DW-1:0] rdData
);
    logic [MEM_DW-1:0] memArray [MEM_DEPTH];

    // No reset term: contents persist
    always_ff @(posedge clk) begin
        if (wrEn) begin
            memArray[wrAddr] <= wrData;
        end
        rdData <= memArray[rdAddr];
    end
endmodule

// File: core/cspd_ctrl.sv
/*
 * Configuration-status and power-down controller top level.
 * Assumes pins synchronous to clk; init and done pins resolved outside from enables.
 */
`timescale 1ns/1ps
module cspd_ctrl
    import cspd_pkg::*;
#(
    parameter int STABLE_CYC = STABLE_CYC_DEF,
    parameter int CLEAR_CYC  = CLEAR_CYC_DEF,
    parameter int MASTER_CYC = MASTER_WAIT_CYC,
    parameter bit SCAN_USED  = 1'b0
)(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Power-down and clear
    input  wire logic                  power_down_n,
    input  wire logic                  clearN,
    // Init pin, open drain
    input  wire logic                  initIn,
    output logic                       initOut,
    output logic                       initOe,
    // Completion pin, open drain
    output logic                       doneOut,
    output logic                       doneOe,
    // Mode inputs and config stream
    input  wire logic [1:0]            modeIn,
    input  wire cspd_cfg_t             cfgIn,
    // Busy outputs
    output logic                       config_busy_high,
    output logic                       config_busy_low_n,
    // User I/O
    input  wire logic [NUM_USER_IO-1:0] userPinIn,
    input  wire cspd_io_t              userLogic,
    output logic [NUM_USER_IO-1:0]     userIn,
    output cspd_io_t                   userPins,
    // Global inputs
    input  wire logic [NUM_GLOBAL-1:0] primary_global_inputs,
    output logic [NUM_GLOBAL-1:0]      globalNet,
    output logic [NUM_GLOBAL-1:0]      globalIo,
    input  wire logic [NUM_GLOBAL-1:0] globalSelect,
    // Test pins
    input  wire logic [2:0]            testPinIn,
    output logic [2:0]                 testToLogic,
    input  wire logic                  testOutData,
    input  wire logic                  testOutEn,
    output logic                       testOutPin,
    output logic                       testOutOe,
    output logic                       scanActive,
    // Status
    output logic [1:0]                 modeLatched,
    output logic                       powerDownActive,
    output logic [MEM_DW-1:0]          cfgWord
);
    cspd_state_t       state_ff;
    cspd_state_t       nxt_state;
    logic              pdSync1_ff;
    logic              pdSync2_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic [MEM_AW-1:0] wrPtr_ff;
    logic              loaded_ff;
    logic              resume_ff;
    logic              inputsOn_ff;
    logic              outputsOn_ff;
    logic              pdDown;
    logic              cntDone;
    logic [CNT_W-1:0]  cntLoad;
    logic [MEM_DW-1:0] shift_ff;
    logic [2:0]        bitCnt_ff;
    logic [MEM_DW-1:0] rdData;

    function automatic logic [CNT_W-1:0] cycLoad(input int cyc);
        cycLoad = CNT_W'(cyc - 1);
    endfunction

    // Power-down synchroniser
    always_ff @(posedge clk) begin
        if (reset) begin
            pdSync1_ff <= 1'b1;
            pdSync2_ff <= 1'b1;
        end else begin
            pdSync1_ff <= power_down_n;
            pdSync2_ff <= pdSync1_ff;
        end
    end
    assign pdDown  = !pdSync2_ff;
    assign cntDone = (cnt_ff == '0);

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        cntLoad   = '0;
        case (state_ff)
            ST_STABILISE: begin
                if (cntDone) begin
                    nxt_state = ST_CLEAR;
                    cntLoad   = cycLoad(CLEAR_CYC);
                end
            end
            ST_CLEAR: begin
                if (cntDone && clearN) begin
                    nxt_state = ST_CLEAR_LAST;
                    cntLoad   = cycLoad(CLEAR_CYC);
                end else if (cntDone) begin
                    cntLoad   = cycLoad(CLEAR_CYC);
                end
            end
            ST_CLEAR_LAST: begin
                if (cntDone) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (initIn && !pdDown) begin
                    if (modeIn == MODE_MASTER_SERIAL) begin
                        nxt_state = ST_MASTER_WAIT;
                        cntLoad   = cycLoad(MASTER_CYC);
                    end else begin
                        nxt_state = ST_CONFIG;
                    end
                end
            end
            ST_MASTER_WAIT: begin
                if (!initIn || pdDown) begin
                    nxt_state = ST_WAIT;
                end else if (cntDone) begin
                    nxt_state = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (pdDown) begin
                    nxt_state = ST_WAIT;
                end else if (cfgIn.configError) begin
                    nxt_state = ST_ERROR;
                end else if (cfgIn.configEnd) begin
                    nxt_state = ST_INPUTS_ON;
                end
            end
            ST_ERROR: begin
                if (pdDown) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_INPUTS_ON: nxt_state = pdDown ? ST_INPUTS_ON : ST_USER;
            ST_USER:      nxt_state = pdDown ? ST_INPUTS_ON : ST_USER;
            default:      nxt_state = ST_STABILISE;
        endcase
        if (!clearN && state_ff != ST_CLEAR) begin
            nxt_state = ST_CLEAR;
            cntLoad   = cycLoad(CLEAR_CYC);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_STABILISE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Shared interval counter
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_ff <= CNT_W'(STABLE_CYC - 1);
        end else if (nxt_state != state_ff || (state_ff == ST_CLEAR && cntDone)) begin
            cnt_ff <= cntLoad;
        end else if (!cntDone) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // Mode capture when leaving wait
    always_ff @(posedge clk) begin
        if (reset) begin
            modeLatched <= MODE_RESET_VAL;
        end else if (state_ff == ST_WAIT && initIn && !pdDown) begin
            modeLatched <= modeIn;
        end
    end

    // Config data loading into memory
    always_ff @(posedge clk) begin
        if (reset || state_ff == ST_WAIT) begin
            shift_ff  <= '0;
            bitCnt_ff <= '0;
            wrPtr_ff  <= '0;
            loaded_ff <= 1'b0;
        end else if (state_ff == ST_CONFIG && !pdDown) begin
            if (cfgIn.configStart) begin
                shift_ff  <= {shift_ff[MEM_DW-2:0], cfgIn.configData};
                bitCnt_ff <= bitCnt_ff + 1'b1;
                if (bitCnt_ff == 3'h7) begin
                    wrPtr_ff <= wrPtr_ff + 1'b1;
                end
            end
        end else if (state_ff == ST_USER) begin
            loaded_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            resume_ff <= 1'b0;
        end else begin
            resume_ff <= (state_ff == ST_CONFIG) && pdDown;
        end
    end

    cspd_cfg_mem u_mem (
        .clk    (clk),
        .wrEn   (state_ff == ST_CONFIG && !pdDown && cfgIn.configStart && bitCnt_ff == 3'h7),
        .wrAddr (wrPtr_ff),
        .wrData ({shift_ff[MEM_DW-2:0], cfgIn.configData}),
        .rdAddr (wrPtr_ff),
        .rdData (rdData)
    );

    // Two-step enable ladder
    always_ff @(posedge clk) begin
        if (reset || pdDown) begin
            inputsOn_ff  <= 1'b0;
            outputsOn_ff <= 1'b0;
        end else begin
            inputsOn_ff  <= (state_ff == ST_INPUTS_ON || state_ff == ST_USER);
            outputsOn_ff <= inputsOn_ff && state_ff == ST_USER;
        end
    end

    // Pin drivers
    always_ff @(posedge clk) begin
        if (reset) begin
            initOut           <= 1'b0;
            initOe            <= 1'b1;
            doneOut           <= 1'b0;
            doneOe            <= 1'b1;
            config_busy_high  <= 1'b1;
            config_busy_low_n <= 1'b0;
            userIn            <= '0;
            userPins          <= '0;
            globalNet         <= '0;
            globalIo          <= '0;
            testToLogic       <= '0;
            testOutPin        <= 1'b0;
            testOutOe         <= 1'b0;
            scanActive        <= 1'b1;
            powerDownActive   <= 1'b0;
            cfgWord           <= '0;
        end else begin
            initOut <= 1'b0;
            initOe  <= (state_ff == ST_STABILISE || state_ff == ST_CLEAR ||
                        state_ff == ST_CLEAR_LAST)
                    || state_ff == ST_ERROR;
            if (outputsOn_ff) begin
                initOut <= userLogic.out[0];
                initOe  <= userLogic.oe[0];
            end
            doneOut <= 1'b0;
            doneOe  <= !(state_ff == ST_INPUTS_ON || state_ff == ST_USER);
            config_busy_high  <= outputsOn_ff ? userLogic.out[1] : 1'b1;
            config_busy_low_n <= outputsOn_ff ? userLogic.out[2] : 1'b0;
            userIn   <= inputsOn_ff ? userPinIn : '0;
            userPins <= outputsOn_ff ? userLogic : '0;
            globalNet <= inputsOn_ff ? (primary_global_inputs & globalSelect) : '0;
            globalIo  <= inputsOn_ff ? (primary_global_inputs & ~globalSelect) : '0;
            testToLogic <= inputsOn_ff ? testPinIn : '0;
            scanActive  <= SCAN_USED || !loaded_ff && state_ff != ST_USER;
            testOutPin  <= testOutData;
            testOutOe   <= outputsOn_ff && !SCAN_USED && testOutEn;
            powerDownActive <= pdDown;
            cfgWord         <= rdData;
        end
    end

    // Checks
    sequence s_pd_exit;
        $fell(pdDown) && state_ff == ST_INPUTS_ON && clearN;
    endsequence
    sequence s_ladder;
        inputsOn_ff && !outputsOn_ff ##1 outputsOn_ff;
    endsequence
    property p_release;
        @(posedge clk) disable iff (reset) s_pd_exit |=> s_ladder;
    endproperty
    a_release: assert property (p_release)
        else $error("Release ladder wrong");
    property p_pd_outputs;
        @(posedge clk) disable iff (reset) pdDown |=> !outputsOn_ff;
    endproperty
    a_pd_outputs: assert property (p_pd_outputs)
        else $error("Outputs on in power-down");
    property p_pd_pins;
        @(posedge clk) disable iff (reset) pdDown |-> ##2 userPins.oe == '0;
    endproperty
    a_pd_pins: assert property (p_pd_pins)
        else $error("User pins driven in power-down");
    property p_ladder;
        @(posedge clk) disable iff (reset) $rose(outputsOn_ff) |-> $past(inputsOn_ff, 1);
    endproperty
    a_ladder: assert property (p_ladder) else $error("Outputs before inputs");
    property p_inputs_low;
        @(posedge clk) disable iff (reset) !inputsOn_ff |=> userIn == '0;
    endproperty
    a_inputs_low: assert property (p_inputs_low) else $error("Input not low");
    property p_busy;
        @(posedge clk) disable iff (reset) !outputsOn_ff |=> config_busy_high && !config_busy_low_n;
    endproperty
    a_busy: assert property (p_busy) else $error("Busy pins wrong");
    property p_wait_hold;
        @(posedge clk) disable iff (reset) state_ff == ST_WAIT && !initIn |=> state_ff != ST_CONFIG;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("Left wait with init low");
    property p_error_pin;
        @(posedge clk) disable iff (reset) state_ff == ST_ERROR |=> initOe && !initOut;
    endproperty
    a_error_pin: assert property (p_error_pin) else $error("Error not on init");
    property p_halt;
        @(posedge clk) disable iff (reset)
            state_ff == ST_CONFIG && pdDown && clearN |=> state_ff == ST_WAIT;
    endproperty
    a_halt: assert property (p_halt) else $error("Config not halted");
endmodule

// File: test/cspd_host_model.sv
/*
 * Configuration host model: init wire pull-up and serial image stream.
 * Assumes the testbench calls send_image and drives holdInit and stopReq.
 */
`timescale 1ns/1ps
module cspd_host_model
    import cspd_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Init wire control
    input  wire logic initOe,
    input  wire logic holdInit,
    input  wire logic stopReq,
    output logic      initIn,
    // Config stream
    output cspd_cfg_t cfgIn
);
    // Pull-up wire, low when either party pulls
    assign initIn = ~(initOe | holdInit);

    initial cfgIn = '0;

    // Image of MEM_DEPTH words unless stopReq cuts it short, MSB first, one bit a cycle
    task automatic send_image(input bit withErr, input logic [MEM_DW-1:0] word);
        int w;
        int b;
        for (w = 0; w < MEM_DEPTH && !stopReq; w++) begin
            for (b = MEM_DW - 1; b >= 0 && !stopReq; b--) begin
                @(posedge clk);
                #1;
                cfgIn.configStart = 1'b1;
                cfgIn.configData  = word[b];
                cfgIn.configError = withErr && (w == 3);
            end
        end
        @(posedge clk);
        #1;
        cfgIn.configStart = 1'b0;
        cfgIn.configError = 1'b0;
        cfgIn.configData  = ~cfgIn.configData;
        cfgIn.configEnd   = !stopReq;
        @(posedge clk);
        #1;
        cfgIn.configEnd   = 1'b0;
        cfgIn.configData  = ~cfgIn.configData;
    endtask
endmodule

// File: test/test_config_status_powerdown_ctrl.sv
/*
 * Self-checking bench for the configuration-status and power-down controller.
 * Assumes the host model answers on the init wire and config stream.
 */
`timescale 1ns/1ps
module test_config_status_powerdown_ctrl
    import cspd_pkg::*;
;
    localparam int MC = 5;
    logic clk = 1'b0, reset = 1'b1, power_down_n = 1'b1, clearN = 1'b1;
    logic holdInit = 1'b0, stopReq = 1'b0, initIn, initOut, initOe, doneOut, doneOe;
    logic [1:0] modeIn = MODE_MASTER_SERIAL, modeLatched;
    logic [7:0] userPinIn = 8'h5a, userIn, cfgWord;
    logic [3:0] pgi = 4'hf, globalSelect = 4'h3, globalNet, globalIo;
    logic [2:0] testPinIn = 3'h5, testToLogic;
    logic testOutPin, testOutOe, scanActive, powerDownActive, busyHigh, busyLowN;
    logic tdoData = 1'b1, tdoEn = 1'b1;
    cspd_cfg_t cfgIn;
    cspd_io_t userLogic = '{out: 8'h04, oe: 8'hff}, userPins;
    int error_cnt = 0, checked = 0;

    cspd_ctrl #(.MASTER_CYC(MC), .SCAN_USED(1'b0)) dut (
        .clk(clk), .reset(reset), .power_down_n(power_down_n), .clearN(clearN),
        .initIn(initIn), .initOut(initOut), .initOe(initOe), .doneOut(doneOut),
        .doneOe(doneOe), .modeIn(modeIn), .cfgIn(cfgIn), .config_busy_high(busyHigh),
        .config_busy_low_n(busyLowN), .userPinIn(userPinIn), .userLogic(userLogic),
        .userIn(userIn), .userPins(userPins), .primary_global_inputs(pgi),
        .globalNet(globalNet), .globalIo(globalIo), .globalSelect(globalSelect),
        .testPinIn(testPinIn), .testToLogic(testToLogic), .testOutData(tdoData),
        .testOutEn(tdoEn), .testOutPin(testOutPin), .testOutOe(testOutOe),
        .scanActive(scanActive), .modeLatched(modeLatched),
        .powerDownActive(powerDownActive), .cfgWord(cfgWord));

    cspd_host_model host (.clk(clk), .initOe(initOe), .holdInit(holdInit),
        .stopReq(stopReq), .initIn(initIn), .cfgIn(cfgIn));

    always #5 clk = ~clk;

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task do_reset;
        reset = 1'b1;
        power_down_n = 1'b1;
        stopReq = 1'b0;
        tick(4);
        reset = 1'b0;
    endtask

    task bring_up;
        int n;
        for (n = 0; n < 400 && initIn !== 1'b1; n++) tick(1);
        check("initIn released", 1, initIn);
        tick(2 * MC + 4);
    endtask

    // Cycle of inputs on must precede cycle of outputs on
    task measure_enable;
        int n, inCyc, outCyc;
        inCyc = -1;
        outCyc = -1;
        for (n = 0; n < 60; n++) begin
            if (inCyc < 0 && userIn === 8'h5a) inCyc = n;
            if (outCyc < 0 && userPins.oe === 8'hff) outCyc = n;
            tick(1);
        end
        check("inputs enabled", 1, inCyc >= 0);
        check("outputs after inputs", 1, outCyc > inCyc);
    endtask

    task t_reset_state;
        tick(1);
        check("initOe at start", 1, initOe);
        check("busy high", 1, busyHigh);
        check("busy low", 0, busyLowN);
        check("done pulled", 1, doneOe);
    endtask

    task t_clear;
        int n;
        clearN = 1'b0;
        do_reset;
        tick(60);
        check("init held in clear", 1, initOe);
        clearN = 1'b1;
        for (n = 0; n < 100 && initOe !== 1'b0; n++) tick(1);
        check("one more clear", 1, n >= CLEAR_CYC_DEF);
        check("clear bounded", 1, n <= 2 * CLEAR_CYC_DEF + 3);
    endtask

    task t_hold_init;
        do_reset;
        holdInit = 1'b1;
        modeIn = 2'h1;
        tick(80);
        check("wait while held", 1, busyHigh);
        check("mode not sampled", MODE_RESET_VAL, modeLatched);
        modeIn = MODE_MASTER_SERIAL;
        tick(1);
        holdInit = 1'b0;
        bring_up;
        check("mode sampled", MODE_MASTER_SERIAL, modeLatched);
    endtask

    task t_config;
        host.send_image(1'b0, 8'ha5);
        measure_enable;
        check("busy high user", 0, busyHigh);
        check("busy low user", 1, busyLowN);
        check("done released", 0, doneOe);
        check("user out", 8'h04, userPins.out);
        check("image word", 8'ha5, cfgWord);
        check("global net", 4'h3, globalNet);
        check("global io", 4'hc, globalIo);
        check("test inputs", 3'h5, testToLogic);
        check("scan off", 0, scanActive);
        check("test out", 2'h3, {testOutPin, testOutOe});
        tdoData = 1'b0;
        tdoEn = 1'b0;
        tick(2);
        check("test out off", 2'h0, {testOutPin, testOutOe});
    endtask

    task t_power_down;
        power_down_n = 1'b0;
        tick(50);
        check("pd active", 1, powerDownActive);
        check("pd outputs off", 0, userPins.oe);
        check("pd inputs low", 0, userIn);
        check("pd globals low", 0, globalNet);
        power_down_n = 1'b1;
        measure_enable;
        check("image kept", 8'ha5, cfgWord);
    endtask

    task t_pd_config;
        do_reset;
        bring_up;
        fork
            host.send_image(1'b0, 8'ha5);
            begin
                tick(40);
                power_down_n = 1'b0;
                stopReq = 1'b1;
            end
        join
        tick(10);
        power_down_n = 1'b1;
        stopReq = 1'b0;
        tick(30);
        check("halted not done", 1, doneOe);
        check("halted busy", 1, busyHigh);
        bring_up;
        host.send_image(1'b0, 8'ha5);
        measure_enable;
        check("restart done", 0, doneOe);
        check("restart image", 8'ha5, cfgWord);
    endtask

    task t_error;
        do_reset;
        bring_up;
        host.send_image(1'b1, 8'ha5);
        tick(20);
        check("error on init", 1, initOe);
        check("error not done", 1, doneOe);
        check("error busy", 1, busyHigh);
    endtask

    initial begin
        #1;
        do_reset;
        t_reset_state;
        t_clear;
        t_hold_init;
        t_config;
        t_power_down;
        t_pd_config;
        t_error;
        end_sim;
    end

    initial begin
        #500000;
        error_cnt++;
        end_sim;
    end
endmodule
